/* verilog/scrb_pkg.sv */
// Purpose: constants for the synthesizer control register bank
// Assumes: 32-bit serial words, address in bits 2:0, read flag in bit 31
// Notes: field positions are given as top bit plus width
package scrb_pkg;
  // ==========================================================
  // word framing
  localparam int WORD_BITS = 32;
  localparam int READ_BIT = 31;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_REG0 = 3'h0;
  localparam logic [2:0] ADDR_REG1 = 3'h1;
  localparam logic [2:0] ADDR_REG2 = 3'h2;
  localparam logic [2:0] ADDR_REG3 = 3'h3;
  localparam logic [2:0] ADDR_REG4 = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_REG0 = 32'h383c0000;
  localparam logic [31:0] RST_REG1 = 32'h00000001;
  localparam logic [31:0] RST_REG2 = 32'h0000fffa;
  localparam logic [31:0] RST_REG3 = 32'h00000043;
  localparam logic [31:0] RST_REG4 = 32'h00000004;
  // ==========================================================
  // register 0 fields
  localparam int R0_MUX_HI = 30;
  localparam int R0_N_HI = 26;
  localparam int R0_F_HI = 14;
  // register 1 fields
  localparam int R1_NUP_HI = 30;
  localparam int R1_HALVER_BIT = 25;
  localparam int R1_RUP_HI = 19;
  localparam int R1_PHASE_HI = 14;
  // register 2 fields
  localparam int R2_NOISE_HI = 30;
  localparam int R2_SLIP_BIT = 28;
  localparam int R2_CP_HI = 27;
  localparam int R2_RHALVE_BIT = 21;
  localparam int R2_DBL_BIT = 20;
  localparam int R2_RLO_HI = 19;
  localparam int R2_MOD_HI = 14;
  // register 3 fields
  localparam int R3_ZFRAC_BIT = 17;
  localparam int R3_CPT_HI = 16;
  localparam int R3_REINIT_BIT = 14;
  localparam int R3_CLAMP_BIT = 13;
  localparam int R3_LIN_HI = 12;
  localparam int R3_WHOLE_BIT = 10;
  localparam int R3_LDTYPE_BIT = 9;
  localparam int R3_LDSPEED_BIT = 8;
  localparam int R3_LDWIN_BIT = 7;
  localparam int R3_POL_BIT = 6;
  localparam int R3_PDN_BIT = 5;
  localparam int R3_FLOAT_BIT = 4;
  localparam int R3_CLR_BIT = 3;
  // register 4 fields
  localparam int R4_REFOFF_BIT = 21;
  localparam int R4_CDM_HI = 20;
  localparam int R4_DIVIDER_COUNT_HI = 18;
  localparam int R4_CONV_HI = 6;
  localparam int R4_TRIG_BIT = 3;
  // status fields
  localparam int ST_POR_BIT = 11;
  localparam int ST_VALID_BIT = 10;
  localparam int ST_RES_HI = 9;
  localparam int ST_RES_LO = 3;
  // ==========================================================
  // codes
  localparam logic [3:0] MUX_SERIAL_OUT = 4'h7;
  localparam logic [1:0] CDM_FAST_LOCK = 2'h1;
  localparam logic [2:0] CONV_TEMP = 3'h1;
  // ==========================================================
  // timing: conversion time at a 100 ns system clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 100000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);
  typedef enum logic [1:0] {
    CONV_IDLE = 2'h0,
    CONV_BUSY = 2'h1,
    CONV_DONE = 2'h3
  } scrb_conv_e;
endpackage

/* verilog/scrb_register_bank.sv */
// Purpose: register bank of a fractional/integer-N synthesizer behind a
//   three-wire serial port (serial clock, data, load enable)
// Assumes: serial pins are synchronous to sys_clk and slower than it
// Notes: readback leaves on the test output pin, msb first
//
// Contract
// R01 - bit 31 zero writes the addressed register, one requests a read
// R02 - low three word bits address the register; 2, 3, 4 as named
// R03 - register 1 bit 25 selects undivided or divide-by-two rf input
// R04 - ten-bit reference divider split over registers 1 and 2; doubler, halver
// R05 - reference divider, halver, doubler, modulus take effect on register 0 write
// R06 - register 1 bits 14:3 hold the twelve-bit phase value
// R07 - register 2 bits 30:29 pick modulator noise mode; host avoids 01
// R08 - register 2 bit 28 enables cycle slip reduction
// R09 - register 2 bits 27:24 hold charge-pump current code
// R10 - register 2 bits 14:3 hold modulus, valid 2 to 4095
// R11 - zero fraction with bit 17 set forces integer-N mode
// R12 - register 3 bits 16:15 pump test mode; bit 4 floats pump
// R13 - register 3 bit 14 clear reinitialises modulator on each register 0 write
// R14 - bit 13 clamps idle pump; nonzero bits 12:11 enable linearity
// R15 - register 3 bit 10 selects fractional or integer-N mode
// R16 - register 3 bits 9, 8, 7 tune the lock detector
// R17 - register 3 bit 6 sets phase detector polarity
// R18 - register 3 bit 5 shuts down; register 4 bit 21 reference stage
// R19 - register 3 bit 3 holds reference and feedback counters reset
// R20 - register 4 bits 20:19 divider function, bits 18:7 divider count
// R21 - converter mode, start bit; status reports valid bit 10, result 9:3
// R22 - status bit 11 reads one until the status was read back
// R23 - register 0 holds low integer bits 26:15 and fraction 14:3
// R24 - register 1 bits 30:27 hold upper four integer divide bits
// R25 - fast-lock interval starts on each register 0 write when selected
// R26 - readback drives test output pin only with selector code 0111
// R27 - each completed write loads only the register it addresses
`timescale 1ns/10ps

module scrb_register_bank
  import scrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serClk,
  input wire logic serData,
  input wire logic loadEn,
  input wire logic [6:0] tempCode,
  output logic muxOut,
  output logic muxOe,
  output logic inputHalver,
  output logic [9:0] refDivide,
  output logic refHalveEnable,
  output logic refDoublerEnable,
  output logic [11:0] phaseValue,
  output logic [1:0] modulatorNoiseSelect,
  output logic slipReductionEnable,
  output logic [3:0] chargePumpCurrentCode,
  output logic [11:0] modulus,
  output logic [15:0] integerDivide,
  output logic [11:0] fracValue,
  output logic wholeModeActive,
  output logic [1:0] pumpTestMode,
  output logic pumpFloatEnable,
  output logic pumpClampEnable,
  output logic pumpLinearityEnable,
  output logic lockDetectType,
  output logic lockDetectSpeed,
  output logic lockWindowSelect,
  output logic detectorPolarity,
  output logic powerDown,
  output logic refStageOff,
  output logic counterClear,
  output logic [1:0] dividerFunctionSelect,
  output logic [11:0] dividerCount,
  output logic [2:0] converterFunction,
  output logic [3:0] testOutputSelect,
  output logic modulatorReinit,
  output logic fastLockStart,
  output logic conversionBusy
);

  // ==========================================================
  // serial front end
  logic serClkPrev_q;
  logic loadEnPrev_q;
  logic [31:0] shiftIn_q;
  wire serRise = serClk & ~serClkPrev_q;
  wire loadRise = loadEn & ~loadEnPrev_q;

  // pin history for edge detection, pins are already synchronous
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serClkPrev_q <= 1'b0;
      loadEnPrev_q <= 1'b0;
    end else begin
      serClkPrev_q <= serClk;
      loadEnPrev_q <= loadEn;
    end
  end

  // data shifts in msb first; only the last 32 bits count
  // no bit counter: a short frame reuses older bits, so the host
  // must always clock out full words before raising load enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shiftIn_q <= '0;
    end else if (serRise) begin
      shiftIn_q <= {shiftIn_q[WORD_BITS-2:0], serData};
    end
  end

  // ==========================================================
  // word decode
  // judged once, on the load enable rise; the shift register keeps
  // moving afterwards but nothing looks at it until the next rise
  wire [2:0] wordAddr = shiftIn_q[ADDR_W-1:0]; // see R02
  wire wordRead = shiftIn_q[READ_BIT]; // see R01
  wire doWrite = loadRise & ~wordRead; // see R01
  wire doRead = loadRise & wordRead; // see R01
  wire wr0 = doWrite & (wordAddr == ADDR_REG0); // see R27
  wire wr1 = doWrite & (wordAddr == ADDR_REG1); // see R27
  wire wr2 = doWrite & (wordAddr == ADDR_REG2); // see R02
  wire wr3 = doWrite & (wordAddr == ADDR_REG3); // see R02
  wire wr4 = doWrite & (wordAddr == ADDR_REG4); // see R02

  // ==========================================================
  // register storage
  logic [31:0] reg0_q;
  logic [31:0] reg1_q;
  logic [31:0] reg2_q;
  logic [31:0] reg3_q;
  logic [31:0] reg4_q;

  // unmapped write addresses fall through and change nothing
  // reserved codes and unused bits are stored exactly as written;
  // checking them here would hide host mistakes from readback
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg0_q <= RST_REG0;
      reg1_q <= RST_REG1;
      reg2_q <= RST_REG2;
      reg3_q <= RST_REG3;
      reg4_q <= RST_REG4;
    end else begin
      if (wr0) reg0_q <= shiftIn_q; // see R27
      if (wr1) reg1_q <= shiftIn_q; // see R27
      if (wr2) reg2_q <= shiftIn_q; // see R27
      if (wr3) reg3_q <= shiftIn_q; // see R27
      if (wr4) reg4_q <= shiftIn_q; // see R27
    end
  end

  // ==========================================================
  // double-buffered fields
  logic [9:0] refDivide_q;
  logic refHalve_q;
  logic refDoubler_q;
  logic [11:0] modulus_q;
  wire [9:0] refDivideNew = {reg1_q[R1_RUP_HI -: 5],
                             reg2_q[R2_RLO_HI -: 5]}; // see R04

  // shadow copies reach the synthesizer only on a register 0 write
  // the copies take register 1 and 2 as they stood before that write,
  // so a divider change and its frequency word land together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      refDivide_q <= {RST_REG1[R1_RUP_HI -: 5], RST_REG2[R2_RLO_HI -: 5]};
      refHalve_q <= RST_REG2[R2_RHALVE_BIT];
      refDoubler_q <= RST_REG2[R2_DBL_BIT];
      modulus_q <= RST_REG2[R2_MOD_HI -: 12];
    end else if (wr0) begin
      refDivide_q <= refDivideNew; // see R05
      refHalve_q <= reg2_q[R2_RHALVE_BIT]; // see R05
      refDoubler_q <= reg2_q[R2_DBL_BIT]; // see R05
      modulus_q <= reg2_q[R2_MOD_HI -: 12]; // see R05 R10
    end
  end

  // ==========================================================
  // derived mode bits and register-0 events
  logic wholeMode_q;
  logic linearity_q;
  logic reinit_q;
  logic fastLock_q;
  wire fracZero = (reg0_q[R0_F_HI -: 12] == 12'h000);
  wire wholeNext = reg3_q[R3_WHOLE_BIT] // see R15
                   | (fracZero & reg3_q[R3_ZFRAC_BIT]); // see R11
  wire linNext = |reg3_q[R3_LIN_HI -: 2]; // see R14
  wire reinitNext = wr0 & ~reg3_q[R3_REINIT_BIT]; // see R13
  wire fastNext = wr0
                  & (reg4_q[R4_CDM_HI -: 2] == CDM_FAST_LOCK); // see R25

  // registered so these four outputs come straight from a flop
  // costs one cycle of lag on the mode bits, harmless for a loop
  // that settles over microseconds; pulses stand for one cycle only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wholeMode_q <= 1'b0;
      linearity_q <= 1'b0;
      reinit_q <= 1'b0;
      fastLock_q <= 1'b0;
    end else begin
      wholeMode_q <= wholeNext;
      linearity_q <= linNext;
      reinit_q <= reinitNext;
      fastLock_q <= fastNext;
    end
  end

  // ==========================================================
  // temperature converter
  scrb_conv_e convState_q;
  scrb_conv_e convState_d;
  logic [9:0] convCount_q;
  logic [6:0] convResult_q;
  wire convStartReq = wr4 & shiftIn_q[R4_TRIG_BIT]
                      & (shiftIn_q[R4_CONV_HI -: 3] == CONV_TEMP); // see R21
  wire convEnd = (convState_q == CONV_BUSY) & (convCount_q == CONV_LAST);

  // a new start restarts a running conversion and drops valid
  // illegal code 2'h2 falls back to idle rather than hanging
  always_comb begin
    convState_d = convState_q;
    unique case (convState_q)
      CONV_IDLE: if (convStartReq) convState_d = CONV_BUSY;
      CONV_BUSY: if (convEnd) convState_d = CONV_DONE;
      CONV_DONE: if (convStartReq) convState_d = CONV_BUSY;
      default: convState_d = CONV_IDLE;
    endcase
  end

  // result is captured once, at the end of the conversion time
  // the counter runs freely while idle; only busy looks at it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      convState_q <= CONV_IDLE;
      convCount_q <= '0;
      convResult_q <= '0;
    end else begin
      convState_q <= convState_d;
      convCount_q <= (convStartReq | convEnd) ? '0 : convCount_q + 10'h001;
      if (convEnd) convResult_q <= tempCode; // see R21
    end
  end

  // ==========================================================
  // readback
  logic powerUp_q;
  logic [31:0] shiftOut_q;
  logic muxOut_q;
  logic muxOe_q;
  wire convValid = (convState_q == CONV_DONE); // see R21
  wire [31:0] statusWord = {1'b1, 19'h00000, powerUp_q, convValid,
                            convResult_q, ADDR_STATUS}; // see R21 R22
  wire serialSel = (reg0_q[R0_MUX_HI -: 4] == MUX_SERIAL_OUT); // see R26
  wire statusRead = doRead & (wordAddr == ADDR_STATUS) & serialSel;
  logic [31:0] readWord;

  // selection of the word to send back; unmapped reads return zero
  // the status word is built on the fly so a read always sees the
  // flag and converter state of the cycle in which it was requested
  always_comb begin
    unique case (wordAddr)
      ADDR_REG0: readWord = reg0_q;
      ADDR_REG1: readWord = reg1_q;
      ADDR_REG2: readWord = reg2_q;
      ADDR_REG3: readWord = reg3_q;
      ADDR_REG4: readWord = reg4_q;
      ADDR_STATUS: readWord = statusWord;
      default: readWord = '0;
    endcase
  end

  // power-up flag is only set by reset, so no set/clear race exists
  // a read with the test pin elsewhere keeps the flag, as no data left
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powerUp_q <= 1'b1;
    end else if (statusRead) begin
      powerUp_q <= 1'b0; // see R22
    end
  end

  // loaded on the read request, shifted on each serial clock rise
  // a read outranks a shift in the same cycle: the snapshot must win
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shiftOut_q <= '0;
    end else if (doRead) begin
      shiftOut_q <= readWord; // see R01
    end else if (serRise) begin
      shiftOut_q <= {shiftOut_q[WORD_BITS-2:0], 1'b0};
    end
  end

  // pin stays released unless the serial output code is chosen
  // enable follows the selector alone, so the pin is driven even
  // between reads; it then shows zeros shifted in behind the word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      muxOut_q <= 1'b0;
      muxOe_q <= 1'b0;
    end else begin
      muxOut_q <= serialSel & shiftOut_q[READ_BIT]; // see R26
      muxOe_q <= serialSel; // see R26
    end
  end

  // ==========================================================
  // field outputs, wired straight from register flops except conversionBusy, decoded from the converter state
  // plain fields are live as soon as their register is written;
  // only the double-buffered ones wait for register 0
  assign muxOut = muxOut_q;
  assign muxOe = muxOe_q;
  assign inputHalver = reg1_q[R1_HALVER_BIT]; // see R03
  assign refDivide = refDivide_q; // see R04
  assign refHalveEnable = refHalve_q; // see R04
  assign refDoublerEnable = refDoubler_q; // see R04
  assign phaseValue = reg1_q[R1_PHASE_HI -: 12]; // see R06
  assign modulatorNoiseSelect = reg2_q[R2_NOISE_HI -: 2]; // see R07
  assign slipReductionEnable = reg2_q[R2_SLIP_BIT]; // see R08
  assign chargePumpCurrentCode = reg2_q[R2_CP_HI -: 4]; // see R09
  assign modulus = modulus_q; // see R10
  assign integerDivide = {reg1_q[R1_NUP_HI -: 4],
                          reg0_q[R0_N_HI -: 12]}; // see R23 R24
  assign fracValue = reg0_q[R0_F_HI -: 12]; // see R23
  assign wholeModeActive = wholeMode_q; // see R11 R15
  assign pumpTestMode = reg3_q[R3_CPT_HI -: 2]; // see R12
  assign pumpFloatEnable = reg3_q[R3_FLOAT_BIT]; // see R12
  assign pumpClampEnable = reg3_q[R3_CLAMP_BIT]; // see R14
  assign pumpLinearityEnable = linearity_q; // see R14
  assign lockDetectType = reg3_q[R3_LDTYPE_BIT]; // see R16
  assign lockDetectSpeed = reg3_q[R3_LDSPEED_BIT]; // see R16
  assign lockWindowSelect = reg3_q[R3_LDWIN_BIT]; // see R16
  assign detectorPolarity = reg3_q[R3_POL_BIT]; // see R17
  assign powerDown = reg3_q[R3_PDN_BIT]; // see R18
  assign refStageOff = reg4_q[R4_REFOFF_BIT]; // see R18
  assign counterClear = reg3_q[R3_CLR_BIT]; // see R19
  assign dividerFunctionSelect = reg4_q[R4_CDM_HI -: 2]; // see R20
  assign dividerCount = reg4_q[R4_DIVIDER_COUNT_HI -: 12]; // see R20
  assign converterFunction = reg4_q[R4_CONV_HI -: 3]; // see R21
  assign testOutputSelect = reg0_q[R0_MUX_HI -: 4];
  assign modulatorReinit = reinit_q; // see R13
  assign fastLockStart = fastLock_q; // see R25
  assign conversionBusy = (convState_q == CONV_BUSY);

endmodule

/* testbench/scrb_props.sv */
// Purpose: concurrent checks on the register bank ports
// Assumes: serial pins sampled on rising sys_clk, as in the bank
// Notes: rebuilds each shifted word to know the access it carries
`timescale 1ns/10ps

module scrb_props
  import scrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serClk,
  input wire logic serData,
  input wire logic loadEn,
  input wire logic muxOut,
  input wire logic muxOe,
  input wire logic inputHalver,
  input wire logic [11:0] phaseValue,
  input wire logic [11:0] modulus,
  input wire logic [11:0] fracValue,
  input wire logic powerDown,
  input wire logic counterClear,
  input wire logic [1:0] dividerFunctionSelect,
  input wire logic [11:0] dividerCount,
  input wire logic [3:0] testOutputSelect,
  input wire logic modulatorReinit,
  input wire logic fastLockStart,
  input wire logic conversionBusy
);
  // ==========================================================
  // word tracking: same edge detection as the bank itself
  logic sck_q;
  logic le_q;
  logic [31:0] word_q;
  wire leRise = loadEn & ~le_q;
  wire isWr = leRise & ~word_q[31];
  wire [2:0] adr = word_q[2:0];
  // shift on every sampled serial clock rise, msb first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      le_q <= 1'b0;
      word_q <= 32'h0;
    end else begin
      sck_q <= serClk;
      le_q <= loadEn;
      if (serClk & ~sck_q) word_q <= {word_q[30:0], serData};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // checks
  AST_REG0: assert property (isWr && adr == ADDR_REG0 |=>
    fracValue == $past(word_q[14:3]) &&
    testOutputSelect == $past(word_q[30:27]))
    else $error("register 0 fields not loaded");
  AST_REG1: assert property (isWr && adr == ADDR_REG1 |=>
    phaseValue == $past(word_q[14:3]) && inputHalver == $past(word_q[25]))
    else $error("register 1 fields not loaded");
  AST_REG3: assert property (isWr && adr == ADDR_REG3 |=>
    powerDown == $past(word_q[5]) && counterClear == $past(word_q[3]))
    else $error("register 3 fields not loaded");
  AST_REG4: assert property (isWr && adr == ADDR_REG4 |=>
    dividerCount == $past(word_q[18:7]) &&
    dividerFunctionSelect == $past(word_q[20:19]))
    else $error("register 4 fields not loaded");
  AST_DBUF: assert property (isWr && adr != ADDR_REG0 |=>
    $stable(modulus)) else $error("modulus moved without register 0");
  AST_UNMAPPED: assert property (isWr && adr > 3'h4 |=>
    $stable(phaseValue) && $stable(dividerCount) && $stable(fracValue))
    else $error("write to unmapped address changed a field");
  AST_PULSE_CAUSE: assert property (modulatorReinit || fastLockStart |->
    $past(isWr && adr == ADDR_REG0))
    else $error("pulse without register 0 write");
  AST_FAST: assert property (isWr && adr == ADDR_REG0 &&
    dividerFunctionSelect == CDM_FAST_LOCK |-> ##1 fastLockStart)
    else $error("fast-lock start missing");
  AST_OE_ON: assert property ((testOutputSelect == MUX_SERIAL_OUT) [*2]
    |-> muxOe) else $error("test pin not driven in serial mode");
  AST_OE_OFF: assert property ((testOutputSelect != MUX_SERIAL_OUT) [*2]
    |-> !muxOe) else $error("test pin driven outside serial mode");
  AST_RDBIT: assert property (leRise && word_q[31] &&
    adr == ADDR_STATUS && muxOe |-> ##2 muxOut)
    else $error("status read flag bit missing");
  AST_CONV: assert property (isWr && adr == ADDR_REG4 &&
    word_q[6:3] == 4'h3 |-> ##[1:3] conversionBusy)
    else $error("conversion did not start");
  // main scenarios reached
  COV_WR0: cover property (isWr && adr == ADDR_REG0);
  COV_FAST: cover property (fastLockStart);
  COV_CONV: cover property ($fell(conversionBusy));
endmodule

bind scrb_register_bank scrb_props u_props (.*);

/* testbench/scrb_host_model.sv */
// Purpose: host controller on the three-wire serial link
// Assumes: pins change on falling sys_clk only
// Notes: each serial clock phase lasts two system cycles, low phases three during readback
`timescale 1ns/10ps

module scrb_host_model (
  input wire logic sys_clk,
  input wire logic muxOut,
  output logic serClk,
  output logic serData,
  output logic loadEn
);
  // ==========================================================
  // link idles low; clock stands still between frames
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    loadEn = 1'b0;
  end
  // one serial clock pulse, two cycles per phase
  task automatic pulse();
    repeat (2) @(negedge sys_clk);
    serClk = 1'b1;
    repeat (2) @(negedge sys_clk);
    serClk = 1'b0;
  endtask
  // 32 bits msb first, read flag on top, address at the bottom
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serData = w[i];
      pulse();
    end
    repeat (2) @(negedge sys_clk);
    loadEn = 1'b1;
    serData = ~serData; // stale data must not look valid
    repeat (2) @(negedge sys_clk);
    loadEn = 1'b0;
  endtask
  // readback only meaningful with the serial-out selector set
  task automatic recv(input logic [31:0] w, output logic [31:0] r);
    send(w);
    @(negedge sys_clk);
    r[31] = muxOut;
    for (int i = 30; i >= 0; i--) begin
      pulse();
      @(negedge sys_clk);
      r[i] = muxOut;
    end
  endtask
endmodule

/* testbench/scrb_register_bank_tb.sv */
// Purpose: self-checking bench for the synthesizer register bank
// Assumes: host model owns the serial pins
// Notes: a shadow of every register predicts all field outputs
`timescale 1ns/10ps

module scrb_register_bank_tb;
  import scrb_pkg::*;
  logic sys_clk, rst, muxOut, muxOe, inputHalver, refHalveEnable;
  logic refDoublerEnable, slipReductionEnable, wholeModeActive;
  logic pumpFloatEnable, pumpClampEnable, pumpLinearityEnable;
  logic lockDetectType, lockDetectSpeed, lockWindowSelect;
  logic detectorPolarity, powerDown, refStageOff, counterClear;
  logic modulatorReinit, fastLockStart, conversionBusy;
  logic serClk, serData, loadEn;
  logic [1:0] modulatorNoiseSelect, pumpTestMode, dividerFunctionSelect;
  logic [2:0] converterFunction;
  logic [3:0] chargePumpCurrentCode, testOutputSelect;
  logic [6:0] tempCode;
  logic [9:0] refDivide;
  logic [11:0] phaseValue, modulus, fracValue, dividerCount;
  logic [15:0] integerDivide;
  logic [31:0] sh [5];
  logic [31:0] act, r;
  int errorCnt = 0;
  int totalChecks = 0;
  logic [31:0] reinitHits = '0;
  logic [31:0] fastHits = '0;
  // writes: noise never 01, modulus never 0 or 1
  localparam logic [31:0] WL [19] = '{
    32'h5521891a, 32'h7a0ffff9, 32'h3bfffff8, 32'h00080004,
    32'h3bfffff8, 32'h00100004, 32'h003ffff4, 32'h0003fffb,
    32'h38008000, 32'h00020003, 32'h3bfffff8, 32'h00012a53,
    32'h7f3f0012, 32'h7ffffffd, 32'h7ffffffe, 32'h7fffffff,
    32'h00008000, 32'h3bfffff8, 32'h0018009c};

  scrb_register_bank dut (.*);
  scrb_host_model host (.sys_clk(sys_clk), .muxOut(muxOut),
    .serClk(serClk), .serData(serData), .loadEn(loadEn));

  // ==========================================================
  // outputs laid out at their register bit positions
  wire [31:0] v0 = {1'b0, testOutputSelect, integerDivide[11:0],
    fracValue, 3'h0};
  wire [31:0] v1 = {1'b0, integerDivide[15:12], 1'b0, inputHalver, 10'h0,
    phaseValue, 3'h0};
  wire [31:0] v2 = {1'b0, modulatorNoiseSelect, slipReductionEnable,
    chargePumpCurrentCode, 24'h0};
  wire [31:0] v3 = {15'h0, pumpTestMode, 1'b0, pumpClampEnable, 1'b0,
    pumpLinearityEnable, wholeModeActive, lockDetectType, lockDetectSpeed,
    lockWindowSelect, detectorPolarity, powerDown, pumpFloatEnable,
    counterClear, 3'h0};
  wire [31:0] v4 = {10'h0, refStageOff, dividerFunctionSelect,
    dividerCount, converterFunction, 4'h0};
  wire [31:0] va = {8'h0, refDivide, refHalveEnable, refDoublerEnable,
    modulus};

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  // one-cycle pulses are counted while they stand, between two edges
  always @(negedge sys_clk) begin
    reinitHits = reinitHits + {31'h0, modulatorReinit};
    fastHits = fastHits + {31'h0, fastLockStart};
  end

  // ==========================================================
  // checking helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmpAll();
    logic [31:0] e3;
    e3 = sh[3] & 32'h0001a3f8;
    e3[11] = |sh[3][12:11];
    e3[10] = sh[3][10] | ((sh[0][14:3] == 12'h0) & sh[3][17]);
    chk(v0, sh[0] & 32'h7ffffff8);
    chk(v1, sh[1] & 32'h7a007ff8);
    chk(v2, sh[2] & 32'h7f000000);
    chk(v3, e3);
    chk(v4, sh[4] & 32'h003ffff0);
    chk(va, act);
    chk({31'h0, muxOe}, {31'h0, sh[0][30:27] == MUX_SERIAL_OUT});
  endtask
  // a write, then every field against the shadow
  task automatic wr(input logic [31:0] w);
    logic z;
    logic [1:0] pe;
    logic [31:0] h0;
    logic [31:0] h1;
    h0 = reinitHits;
    h1 = fastHits;
    host.send(w);
    z = (w[2:0] == ADDR_REG0);
    if (w[2:0] < 3'h5) sh[w[2:0]] = w;
    if (z) act = {8'h0, sh[1][19:15], sh[2][19:15], sh[2][21:20],
      sh[2][14:3]};
    pe = {z & ~sh[3][14], z & (sh[4][20:19] == CDM_FAST_LOCK)};
    @(negedge sys_clk);
    cmpAll();
    chk(reinitHits - h0, {31'h0, pe[1]});
    chk(fastHits - h1, {31'h0, pe[0]});
  endtask
  // verdict and end of run
  task automatic finalReport();
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    tempCode = 7'h5a;
    sh = '{RST_REG0, RST_REG1, RST_REG2, RST_REG3, RST_REG4};
    act = {8'h0, RST_REG1[19:15], RST_REG2[19:15], RST_REG2[21:20],
      RST_REG2[14:3]};
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    cmpAll();
    host.recv(32'h80000006, r);
    chk(r & 32'hfffff807, 32'h80000806);
    host.recv(32'h80000006, r);
    chk(r & 32'hfffff807, 32'h80000006);
    host.recv(32'h80000005, r);
    chk(r, 32'h0);
    for (int i = 0; i < 19; i++) wr(WL[i]);
    chk({31'h0, conversionBusy}, 32'h1);
    for (int i = 0; i < 1200 && conversionBusy; i++) @(negedge sys_clk);
    chk({31'h0, conversionBusy}, 32'h0);
    host.recv(32'h80000006, r);
    chk(r, {1'b1, 19'h0, 1'b0, 1'b1, 7'h5a, ADDR_STATUS});
    finalReport();
  end

  // hang guard, well above the few thousand cycles needed
  initial begin
    #2000000;
    errorCnt++;
    finalReport();
  end
endmodule
